// >>> scfg_pkg.sv
// constants and types shared by the system configuration register bank
package scfg_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_REMAP    = 8'h00;
  localparam logic [7:0] OFS_PMC      = 8'h04;
  localparam logic [7:0] OFS_EXTI     = 8'h08;
  localparam logic [7:0] OFS_CMP      = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int         ADC_DUTY_BIT = 16;
  localparam int         CMP_EN_BIT   = 0;
  localparam int         CMP_RDY_BIT  = 8;
  localparam int         IRQ_RDY_BIT  = 0;
  localparam int         IRQ_RSV_BIT  = 1;
  localparam int         IRQ_W        = 2;
  localparam int         SRC_W        = 4;
  localparam int         LINES        = 4;
  localparam int         EXTI_W       = SRC_W * LINES;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] PMC_RST      = 32'h0000_0000;
  localparam logic [15:0] EXTI_RST     = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MAP_MAIN_FLASH = 2'h0,
    MAP_SYS_FLASH  = 2'h1,
    MAP_RESERVED   = 2'h2,
    MAP_SRAM       = 2'h3
  } scfg_map_t;

  localparam logic [3:0] SRC_PORT_A = 4'h0;
  localparam logic [3:0] SRC_PORT_B = 4'h1;
  localparam logic [3:0] SRC_PORT_C = 4'h2;
  localparam logic [3:0] SRC_PORT_H = 4'h7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int COMP_SETTLE_NS  = 1000;
  localparam int COMP_SETTLE_CYC =
    (COMP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // boot pins to the mapping that appears at address zero
  function automatic scfg_map_t boot_to_map(input logic primary_boot_pin,
                                            input logic boot1);
    if (!primary_boot_pin) begin
      return MAP_MAIN_FLASH;
    end else if (!boot1) begin
      return MAP_SYS_FLASH;
    end else begin
      return MAP_SRAM;
    end
  endfunction

  // true for a source code that names no port
  function automatic logic src_reserved(input logic [3:0] code);
    return !(code == SRC_PORT_A || code == SRC_PORT_B ||
             code == SRC_PORT_C || code == SRC_PORT_H);
  endfunction

endpackage

// >>> scfg_comp_cell.sv
// compensation cell enable sequencing and ready flag
`timescale 1ns/1ns
module scfg_comp_cell (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic enable_i,
  output logic      ready_o
);
  import scfg_pkg::*;

  typedef enum logic [1:0] {CELL_OFF, CELL_SETTLE, CELL_READY} scfg_cell_t;

  scfg_cell_t state;
  logic [7:0] settle_cnt;

  // the cell stays powered down until software enables it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state      <= CELL_OFF;
      settle_cnt <= 8'h00;
    end else begin
      case (state)
        CELL_OFF: begin
          settle_cnt <= 8'h00;
          if (enable_i) begin
            state <= CELL_SETTLE;
          end
        end
        CELL_SETTLE: begin
          settle_cnt <= settle_cnt + 8'h01;
          if (!enable_i) begin
            state <= CELL_OFF;
          end else if (settle_cnt == 8'(COMP_SETTLE_CYC - 1)) begin
            state <= CELL_READY;
          end
        end
        CELL_READY: begin
          if (!enable_i) begin
            state <= CELL_OFF;
          end
        end
        default: begin
          state <= CELL_OFF;
        end
      endcase
    end
  end

  assign ready_o = (state == CELL_READY); // R3

  // ready lags a cleared enable by one edge, so look one edge back
  a_ready_needs_en: assert property (@(posedge mclk_i) // R1
    disable iff (sys_rst_i) ready_o |-> $past(enable_i))
    else $error("compensation ready while cell disabled");

endmodule

// >>> scfg_exti_mux.sv
// routes gpio pins onto external interrupt lines 0 to 3
`timescale 1ns/1ns
module scfg_exti_mux (
  input  wire logic                        mclk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic [scfg_pkg::EXTI_W-1:0] select_i,
  input  wire logic [3:0]                  port_a_pins_i,
  input  wire logic [3:0]                  port_b_pins_i,
  input  wire logic [3:0]                  port_c_pins_i,
  input  wire logic [3:0]                  port_h_pins_i,
  output logic      [3:0]                  irq_line_o
);
  import scfg_pkg::*;

  logic [15:0] pin_meta;
  logic [15:0] pin_sync;

  // pins are asynchronous to mclk_i
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pin_meta <= 16'h0000;
      pin_sync <= 16'h0000;
    end else begin
      pin_meta <= {port_h_pins_i, port_c_pins_i,
                   port_b_pins_i, port_a_pins_i};
      pin_sync <= pin_meta;
    end
  end

  function automatic logic pick(input logic [3:0] code,
                                input logic [15:0] pins,
                                input int n);
    case (code)
      SRC_PORT_A: return pins[n];
      SRC_PORT_B: return pins[4 + n];
      SRC_PORT_C: return pins[8 + n];
      SRC_PORT_H: return pins[12 + n];
      default:    return 1'b0;
    endcase
  endfunction

  // a reserved code leaves its line quiet rather than guessing a port
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_line_o <= 4'h0;
    end else begin
      for (int n = 0; n < LINES; n++) begin
        irq_line_o[n] <= pick(select_i[SRC_W*n +: SRC_W], // R13 R15
                              pin_sync, n);
      end
    end
  end

  a_line0_port_a: assert property (@(posedge mclk_i) // R15
    disable iff (sys_rst_i)
    (select_i[3:0] == SRC_PORT_A) |=> (irq_line_o[0] == $past(pin_sync[0])))
    else $error("line 0 does not follow port a pin 0");

endmodule

// >>> scfg_top.sv
// system configuration register bank: remap, adc mode, irq source select
//
// Operation
// R1: compensation cell off until software enables it
// R2: software enables cell at fast output speeds
// R3: ready flag set once enabled cell settles
// R4: two-bit remap field selects memory at zero
// R5: remap field loads from boot pins at reset
// R6: main flash boot reads remap as zero
// R7: 00 main, 01 system, 11 sram, 10 reserved
// R8: remap is read-write and drives mapping directly
// R9: remapped memory is reached over code bus; code_bus_route_o is set for system flash and sram only, not main flash
// R10: software sets adc mode bit only when fast
// R11: adc mode bit not set with supply bit; the bit is stored as written and adc_supply_mode_bit_i is not used
// R12: four 4-bit source fields in bits 15:0
// R13: 0000 A, 0001 B, 0010 C, 0111 H
// R14: software keeps remap upper bits at zero
// R15: field n in bits 4n+3:4n selects line n
`timescale 1ns/1ns
module scfg_top (
  input  wire logic                        mclk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [7:0]                  paddr_i,
  input  wire logic [31:0]                 pwdata_i,
  output logic                             pready_o,
  output logic      [31:0]                 prdata_o,
  output logic                             pslverr_o,
  input  wire logic                        primary_boot_pin_i,
  input  wire logic                        secondary_boot_pin_i,
  input  wire logic                        adc_supply_mode_bit_i,
  input  wire logic [3:0]                  port_a_pins_i,
  input  wire logic [3:0]                  port_b_pins_i,
  input  wire logic [3:0]                  port_c_pins_i,
  input  wire logic [3:0]                  port_h_pins_i,
  output logic      [1:0]                  mem_map_o,
  output logic                             map_main_flash_o,
  output logic                             map_sys_flash_o,
  output logic                             map_sram_o,
  output logic                             code_bus_route_o,
  output logic                             adc_duty_mode_bit_o,
  output logic                             comp_cell_enable_o,
  output logic      [3:0]                  irq_line_o,
  output logic                             irq_o
);
  import scfg_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  scfg_map_t         mem_mode;
  logic              adc_duty;
  logic [EXTI_W-1:0] exti_sel;
  logic              cmp_en;
  logic              cmp_ready;
  logic              cmp_ready_d;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [1:0]        boot_meta;
  logic [1:0]        boot_sync;

  logic              acc_wr;
  logic              setup_rd;
  logic              addr_ok;
  logic              wr_remap;
  logic              wr_pmc;
  logic              wr_exti;
  logic              wr_cmp;
  logic              wr_stat;
  logic              wr_mask;
  logic [IRQ_W-1:0]  irq_event;
  logic              rsv_written;

  // ----------------------------------------------------------------
  // boot pin synchroniser
  // ----------------------------------------------------------------
  // pins keep being sampled during reset so the load below sees them
  always_ff @(posedge mclk_i) begin
    boot_meta <= {secondary_boot_pin_i, primary_boot_pin_i};
    boot_sync <= boot_meta;
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic known_offset(input logic [7:0] a);
    return (a == OFS_REMAP) || (a == OFS_PMC) || (a == OFS_EXTI) ||
           (a == OFS_CMP) || (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
  endfunction

  assign addr_ok  = known_offset(paddr_i);
  assign acc_wr   = psel_i && penable_i && pwrite_i && addr_ok;
  assign setup_rd = psel_i && !penable_i && !pwrite_i;
  assign wr_remap = acc_wr && (paddr_i == OFS_REMAP);
  assign wr_pmc   = acc_wr && (paddr_i == OFS_PMC);
  assign wr_exti  = acc_wr && (paddr_i == OFS_EXTI);
  assign wr_cmp   = acc_wr && (paddr_i == OFS_CMP);
  assign wr_stat  = acc_wr && (paddr_i == OFS_IRQ_STAT);
  assign wr_mask  = acc_wr && (paddr_i == OFS_IRQ_MASK);

  // zero wait states: every access completes in its first access cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok;

  // ----------------------------------------------------------------
  // memory remap register
  // ----------------------------------------------------------------
  // sync reset, so the load may take the synchronised pin level;
  // reset must be held at least three edges for the pins to settle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mem_mode <= boot_to_map(boot_sync[0], boot_sync[1]); // R5 R6
    end else if (wr_remap) begin
      mem_mode <= scfg_map_t'(pwdata_i[1:0]); // R4 R8
    end
  end

  assign mem_map_o        = mem_mode;
  assign map_main_flash_o = (mem_mode == MAP_MAIN_FLASH); // R7
  assign map_sys_flash_o  = (mem_mode == MAP_SYS_FLASH); // R7
  assign map_sram_o       = (mem_mode == MAP_SRAM); // R7
  // system flash and sram mappings are fetched over the code bus; main flash and the reserved code are not
  assign code_bus_route_o = map_sys_flash_o || map_sram_o; // R9

  // ----------------------------------------------------------------
  // peripheral mode register
  // ----------------------------------------------------------------
  // clock and supply preconditions are software's to keep; the bit is
  // stored as written so firmware can read back what it asked for
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      adc_duty <= PMC_RST[ADC_DUTY_BIT];
    end else if (wr_pmc) begin
      adc_duty <= pwdata_i[ADC_DUTY_BIT];
    end
  end

  assign adc_duty_mode_bit_o = adc_duty;

  // ----------------------------------------------------------------
  // interrupt source select register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      exti_sel <= EXTI_RST;
    end else if (wr_exti) begin
      exti_sel <= pwdata_i[EXTI_W-1:0]; // R12
    end
  end

  scfg_exti_mux u_exti_mux (
    .mclk_i        (mclk_i),
    .sys_rst_i     (sys_rst_i),
    .select_i      (exti_sel),
    .port_a_pins_i (port_a_pins_i),
    .port_b_pins_i (port_b_pins_i),
    .port_c_pins_i (port_c_pins_i),
    .port_h_pins_i (port_h_pins_i),
    .irq_line_o    (irq_line_o)
  );

  // ----------------------------------------------------------------
  // compensation cell control
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cmp_en <= 1'b0; // R1
    end else if (wr_cmp) begin
      cmp_en <= pwdata_i[CMP_EN_BIT];
    end
  end

  assign comp_cell_enable_o = cmp_en;

  scfg_comp_cell u_comp_cell (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .enable_i  (cmp_en),
    .ready_o   (cmp_ready)
  );

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  function automatic logic any_rsv_src(input logic [EXTI_W-1:0] v);
    logic r;
    r = 1'b0;
    for (int n = 0; n < LINES; n++) begin
      r = r | src_reserved(v[SRC_W*n +: SRC_W]);
    end
    return r;
  endfunction

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cmp_ready_d <= 1'b0;
    end else begin
      cmp_ready_d <= cmp_ready;
    end
  end

  assign rsv_written =
    (wr_remap && (pwdata_i[1:0] == MAP_RESERVED)) ||
    (wr_exti && any_rsv_src(pwdata_i[EXTI_W-1:0]));

  assign irq_event[IRQ_RDY_BIT] = cmp_ready && !cmp_ready_d; // R3
  assign irq_event[IRQ_RSV_BIT] = rsv_written;

  // a new event outranks a write-one clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_stat <= IRQ_RST;
    end else if (wr_stat) begin
      irq_stat <= (irq_stat & ~pwdata_i[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_mask <= IRQ_RST;
    end else if (wr_mask) begin
      irq_mask <= pwdata_i[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // captured in the setup cycle so it is a flop in the access cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_o <= 32'h0000_0000;
      case (paddr_i)
        OFS_REMAP:    prdata_o[1:0] <= mem_mode; // R8
        OFS_PMC:      prdata_o[ADC_DUTY_BIT] <= adc_duty;
        OFS_EXTI:     prdata_o[EXTI_W-1:0] <= exti_sel;
        OFS_CMP: begin
          prdata_o[CMP_EN_BIT]  <= cmp_en;
          prdata_o[CMP_RDY_BIT] <= cmp_ready; // R3
        end
        OFS_IRQ_STAT: prdata_o[IRQ_W-1:0] <= irq_stat;
        OFS_IRQ_MASK: prdata_o[IRQ_W-1:0] <= irq_mask;
        default:      prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  localparam int RDY_MAX = COMP_SETTLE_CYC + 2;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_remap_wr;
    psel_i && penable_i && pwrite_i && (paddr_i == OFS_REMAP);
  endsequence

  sequence s_exti_wr;
    psel_i && penable_i && pwrite_i && (paddr_i == OFS_EXTI);
  endsequence

  sequence s_cmp_on;
    $rose(cmp_en);
  endsequence

  sequence s_pmc_wr;
    psel_i && penable_i && pwrite_i && (paddr_i == OFS_PMC);
  endsequence

  sequence s_rd_setup;
    psel_i && !penable_i && !pwrite_i;
  endsequence

  a_remap_write: assert property ( // R4
    s_remap_wr |=> (mem_map_o == $past(pwdata_i[1:0])))
    else $error("remap field did not take written value");

  a_remap_hold: assert property ( // R8
    !wr_remap |=> $stable(mem_map_o))
    else $error("remap field changed without a write");

  a_boot_load: assert property ( // R5
    $fell(sys_rst_i) |->
      mem_mode == boot_to_map($past(boot_sync[0]), $past(boot_sync[1])))
    else $error("remap not loaded from boot pins");

  a_boot_main: assert property ( // R6
    ($fell(sys_rst_i) && !$past(boot_sync[0])) |-> (mem_map_o == 2'h0))
    else $error("main flash boot did not give remap zero");

  a_map_decode: assert property ( // R7
    $onehot0({map_main_flash_o, map_sys_flash_o, map_sram_o}) &&
    ((mem_map_o == 2'h2) == !(map_main_flash_o || map_sys_flash_o ||
                              map_sram_o)))
    else $error("memory decode not one-hot or reserved code mapped");

  a_code_route: assert property ( // R9
    code_bus_route_o == (mem_map_o == 2'h1 || mem_map_o == 2'h3))
    else $error("code bus route disagrees with remap");

  a_exti_write: assert property ( // R12
    s_exti_wr |=> (exti_sel == $past(pwdata_i[15:0])))
    else $error("source select did not take written value");

  a_comp_off: assert property ( // R1
    !cmp_en |=> !cmp_ready)
    else $error("cell ready without enable");

  a_comp_ready: assert property ( // R3
    s_cmp_on |-> ##[1:RDY_MAX] (cmp_ready || !cmp_en))
    else $error("compensation ready flag late");

  a_irq_sticky: assert property (
    (irq_stat[IRQ_RDY_BIT] && !wr_stat) |=> irq_stat[IRQ_RDY_BIT])
    else $error("sticky status bit lost");

  a_pmc_write: assert property (
    s_pmc_wr |=> (adc_duty_mode_bit_o == $past(pwdata_i[ADC_DUTY_BIT])))
    else $error("adc mode bit did not take written value");

  // read data is taken in setup, so it shows the field one edge back
  a_remap_read: assert property ( // R8
    (s_rd_setup ##0 (paddr_i == OFS_REMAP)) |=>
      (prdata_o == {30'h0, $past(mem_map_o)}))
    else $error("remap read data disagrees with field");

  a_rdy_status: assert property ( // R3
    $rose(cmp_ready) |=> irq_stat[IRQ_RDY_BIT])
    else $error("ready event did not set status bit");

  a_rsv_status: assert property (
    rsv_written |=> irq_stat[IRQ_RSV_BIT])
    else $error("reserved code write did not set status bit");

  a_stat_clear: assert property (
    (wr_stat && pwdata_i[IRQ_RDY_BIT] && !irq_event[IRQ_RDY_BIT]) |=>
      !irq_stat[IRQ_RDY_BIT])
    else $error("write-one clear left status bit set");

endmodule

// >>> scfg_pin_model.sv
// far-side model of the boot straps and gpio port pins
`timescale 1ns/1ns
module scfg_pin_model (
  input  wire logic        mclk_i,
  input  wire logic [1:0]  boot_sel_i,
  input  wire logic [15:0] pins_i,
  output logic             primary_boot_pin_o,
  output logic             boot1_o,
  output logic      [15:0] pins_o
);
  // straps and pins change only after an edge, as a board would show them
  always_ff @(posedge mclk_i) begin
    primary_boot_pin_o <= boot_sel_i[0];
    boot1_o <= boot_sel_i[1];
    pins_o  <= pins_i;
  end
endmodule

// >>> scfg_top_tb.sv
// self-checking bench for the system configuration register bank
`timescale 1ns/1ns
module scfg_top_tb;
  import scfg_pkg::*;
  logic        mclk_i    = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [1:0]  boot_sel  = 2'h0;
  logic [15:0] pin_val   = 16'h0;
  logic        adc_sup   = 1'b0;
  logic        pready, pslverr, primary_boot_pin, boot1, m_main, m_sys, m_sram;
  logic        code_rt, adc_bit, cmp_en, irq;
  logic [31:0] prdata;
  logic [15:0] pins, fld;
  logic [1:0]  mem_map, c;
  logic [3:0]  irq_line, exp_l, nib;
  logic [32:0] exp_q[$];
  logic [32:0] exp_e;
  logic [1:0]  boot_tab [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  logic [1:0]  map_tab [4]  = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [3:0]  src_tab [4]  = '{SRC_PORT_A, SRC_PORT_B, SRC_PORT_C,
                                 SRC_PORT_H};
  int          fails = 0;
  int          check_count = 0;
  int          seed = 32'h5b49;
  int          k, n, p;

  always #10 mclk_i = ~mclk_i;

  scfg_pin_model PINS (.mclk_i(mclk_i), .boot_sel_i(boot_sel),
    .pins_i(pin_val), .primary_boot_pin_o(primary_boot_pin), .boot1_o(boot1), .pins_o(pins));

  scfg_top DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .primary_boot_pin_i(primary_boot_pin),
    .secondary_boot_pin_i(boot1), .adc_supply_mode_bit_i(adc_sup),
    .port_a_pins_i(pins[3:0]), .port_b_pins_i(pins[7:4]),
    .port_c_pins_i(pins[11:8]), .port_h_pins_i(pins[15:12]),
    .mem_map_o(mem_map), .map_main_flash_o(m_main),
    .map_sys_flash_o(m_sys), .map_sram_o(m_sram),
    .code_bus_route_o(code_rt), .adc_duty_mode_bit_o(adc_bit),
    .comp_cell_enable_o(cmp_en), .irq_line_o(irq_line), .irq_o(irq));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // note holds the expected error flag above the expected read word
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int i;
    exp_q.push_back(e);
    @(posedge mclk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk_i);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      fails++;
      test_done();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  task automatic chk_map(input logic [1:0] m);
    chk({26'h0, mem_map, m_main, m_sys, m_sram, code_rt},
        {26'h0, m, m == 2'h0, m == 2'h1, m == 2'h3, m[0]});
  endtask

  task automatic do_reset(input logic [1:0] sel);
    @(posedge mclk_i);
    boot_sel  <= sel;
    sys_rst_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
  endtask

  // completed bus transfers are judged against the oldest note
  always @(posedge mclk_i) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[ERR] %0t transfer with no expectation", $time);
      end else begin
        exp_e = exp_q.pop_front();
        chk({31'h0, pslverr}, {31'h0, exp_e[32]});
        if (!pwrite) chk(prdata, exp_e[31:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    for (k = 0; k < 4; k++) begin
      do_reset(boot_tab[k]);
      c = !boot_tab[k][0] ? 2'h0 : (boot_tab[k][1] ? 2'h3 : 2'h1);
      chk_map(c);
      rd(OFS_REMAP, {30'h0, c});
    end
    rd(OFS_PMC, PMC_RST);
    rd(OFS_EXTI, {16'h0, EXTI_RST});
    rd(OFS_CMP, 32'h0);
    chk({31'h0, cmp_en}, 32'h0);
    for (k = 0; k < 4; k++) begin
      wr(OFS_REMAP, {30'h0, map_tab[k]});
      chk_map(map_tab[k]);
      rd(OFS_REMAP, {30'h0, map_tab[k]});
    end
    rd(OFS_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_STAT, 32'h2);
    rd(OFS_IRQ_STAT, 32'h0);
    wr(OFS_REMAP, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h30, 32'hffff_ffff, {1'b1, 32'h0});
    wr(OFS_PMC, 32'h0001_0000);
    chk({31'h0, adc_bit}, 32'h1);
    rd(OFS_PMC, 32'h0001_0000);
    wr(OFS_PMC, 32'h0);
    chk({31'h0, adc_bit}, 32'h0);
    for (k = 0; k < 8; k++) begin
      for (n = 0; n < 4; n++) fld[4*n +: 4] = src_tab[2'($random(seed))];
      wr(OFS_EXTI, {16'h0, fld});
      pin_val <= 16'($random(seed));
      repeat (6) @(posedge mclk_i);
      @(negedge mclk_i);
      for (n = 0; n < 4; n++) begin
        nib = fld[4*n +: 4];
        p = (nib == SRC_PORT_H) ? 3 : int'(nib);
        exp_l[n] = pin_val[4*p + n];
      end
      chk({28'h0, irq_line}, {28'h0, exp_l});
      rd(OFS_EXTI, {16'h0, fld});
    end
    pin_val <= 16'hffff;
    wr(OFS_EXTI, 32'h0000_0030);
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({28'h0, irq_line}, 32'hd);
    rd(OFS_IRQ_STAT, 32'h2);
    wr(OFS_IRQ_STAT, 32'h2);
    wr(OFS_IRQ_MASK, 32'h1);
    rd(OFS_IRQ_MASK, 32'h1);
    wr(OFS_CMP, 32'h1);
    chk({31'h0, cmp_en}, 32'h1);
    rd(OFS_CMP, 32'h1);
    chk({31'h0, irq}, 32'h0);
    repeat (COMP_SETTLE_CYC + 4) @(posedge mclk_i);
    rd(OFS_CMP, 32'h101);
    rd(OFS_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_IRQ_STAT, 32'h0);
    wr(OFS_CMP, 32'h0);
    repeat (3) @(posedge mclk_i);
    rd(OFS_CMP, 32'h0);
    chk(32'(exp_q.size()), 32'h0);
    test_done();
  end
endmodule
